// [verilog/cidfsk_pkg.sv]
`default_nettype none
package cidfsk_pkg;
   localparam int BAUD_RATE   = 1200;
   localparam int CLK_HZ      = 20_000_000;
   localparam int BIT_CYC_DEF = CLK_HZ / BAUD_RATE;
   localparam int CD_ON_US    = 8000;
   localparam int CD_OFF_US   = 8000;
   localparam int CD_ON_DEF   = (CLK_HZ / 1_000_000) * CD_ON_US;
   localparam int CD_OFF_DEF  = (CLK_HZ / 1_000_000) * CD_OFF_US;
   localparam int DATA_BITS   = 8;
   localparam int AW          = 4;
   localparam int DW          = 32;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_MASK   = 4'h4;
   localparam logic [3:0] ADDR_STATE  = 4'h8;
   localparam logic [3:0] ADDR_WORD   = 4'hC;
   localparam int EV_WORD   = 0;
   localparam int EV_FRAME  = 1;
   localparam int EV_CARR   = 2;
   localparam int EV_N      = 3;
   localparam logic [2:0] MASK_RST = 3'h0;
   localparam logic [1:0] FS_FSK        = 2'h3;
   localparam logic [1:0] FS_TONE_LINE  = 2'h1;
   localparam logic [1:0] FS_TONE_HYB   = 2'h2;
   localparam logic [1:0] FS_OFF        = 2'h0;
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } cidfsk_rx_e;
endpackage : cidfsk_pkg
`default_nettype wire

// [verilog/cidfsk_serial.sv]
`timescale 1ns/1ns
`default_nettype none
module cidfsk_serial
   import cidfsk_pkg::*;
#(
   parameter int BIT_CYCLES = BIT_CYC_DEF,
   parameter int CD_ON_CYC  = CD_ON_DEF,
   parameter int CD_OFF_CYC = CD_OFF_DEF
) (
   input  wire logic          i_clk,
   input  wire logic          i_reset,
   input  wire logic          i_oscillator_input,
   output logic               o_oscillator_output,
   input  wire logic          i_interface_mode_select,
   input  wire logic          i_function_select_a,
   input  wire logic          i_function_select_b,
   input  wire logic          i_line_fsk_bit,
   input  wire logic          i_line_carrier_raw,
   input  wire logic          i_tone_delayed_steer,
   input  wire logic          i_data_shift_clock,
   output logic               o_data_shift_clock,
   output logic               o_data_shift_clock_oe,
   output logic               o_serial_data,
   output logic               o_data_ready_or_tone_steering_n,
   output logic               o_carrier_present_n,
   output logic               o_fsk_enable,
   output logic               o_tone_enable,
   output logic               o_tone_from_line,
   output logic               o_full_power_down,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic          i_wr,
   input  wire logic          i_rd,
   output logic [DW-1:0]      o_rdata,
   output logic               o_irq
);
   localparam int TW = $clog2(BIT_CYCLES + 1);
   localparam int CW = $clog2(((CD_ON_CYC > CD_OFF_CYC) ? CD_ON_CYC : CD_OFF_CYC) + 1);
   localparam logic [TW-1:0] BIT_M1  = TW'(BIT_CYCLES - 1);
   localparam logic [TW-1:0] HALF    = TW'(BIT_CYCLES / 2);
   localparam logic [TW-1:0] HALF_M1 = TW'(BIT_CYCLES / 2 - 1);
   localparam logic [CW-1:0] CD_ON   = CW'(CD_ON_CYC);
   localparam logic [CW-1:0] CD_OFF  = CW'(CD_OFF_CYC);

   // pin synchronisers: mode, fs_a, fs_b, fsk bit, carrier, tone, shift clock
   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic       fsk_d_r;
   logic       hclk_d_r;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sync1_r  <= 7'h09;
         sync2_r  <= 7'h09;
         fsk_d_r  <= 1'b1;
         hclk_d_r <= 1'b0;
      end else begin
         sync1_r  <= {i_data_shift_clock, i_tone_delayed_steer, i_line_carrier_raw,
                      i_line_fsk_bit, i_function_select_b, i_function_select_a,
                      i_interface_mode_select};
         sync2_r  <= sync1_r;
         fsk_d_r  <= sync2_r[3];
         hclk_d_r <= sync2_r[6];
      end
   end

   wire       mode1_s   = sync2_r[0];
   wire [1:0] fs_s      = {sync2_r[2], sync2_r[1]};
   wire       fsk_s     = sync2_r[3];
   wire       carr_s    = sync2_r[4];
   wire       tone_s    = sync2_r[5];
   wire       host_rise = sync2_r[6] & ~hclk_d_r;
   wire       fsk_fall  = fsk_d_r & ~fsk_s;

   // function select decode
   wire pd       = mode1_s & (fs_s == FS_OFF);
   wire fsk_en   = (fs_s == FS_FSK);
   wire tone_en  = ~fsk_en & ~pd;
   wire tone_ln  = (fs_s == FS_TONE_LINE);
   assign o_fsk_enable      = fsk_en;
   assign o_tone_enable     = tone_en;
   assign o_tone_from_line  = tone_ln;
   assign o_full_power_down = pd;
   assign o_oscillator_output = ~i_oscillator_input & ~pd;

   // carrier detect with time hysteresis
   logic          cd_r;
   logic [CW-1:0] cd_cnt_r;
   wire  [CW-1:0] cd_lim = cd_r ? CD_OFF : CD_ON;
   wire           cd_diff = fsk_en & (carr_s != cd_r);
   wire           cd_flip = cd_diff & (cd_cnt_r >= cd_lim - CW'(1));
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cd_r     <= 1'b0;
         cd_cnt_r <= '0;
      end else begin
         cd_cnt_r <= (cd_diff & ~cd_flip) ? cd_cnt_r + CW'(1) : '0;
         cd_r     <= fsk_en & (cd_flip ? ~cd_r : cd_r);
      end
   end
   assign o_carrier_present_n = ~cd_r;

   // character receiver, line path only
   cidfsk_rx_e    st_r;
   cidfsk_rx_e    st_nxt;
   logic [TW-1:0] tmr_r;
   logic [TW-1:0] tmr_nxt;
   logic [2:0]    cnt_r;
   logic [7:0]    byte_r;
   wire           tick = (st_r != RX_IDLE) & (tmr_r == '0);
   wire           word_done = tick & (st_r == RX_STOP);
   always_comb begin
      st_nxt  = st_r;
      tmr_nxt = (tmr_r == '0) ? '0 : tmr_r - TW'(1);
      case (st_r)
         RX_IDLE: begin
            if (cd_r & fsk_fall) begin
               st_nxt  = RX_START;
               tmr_nxt = HALF_M1;
            end
         end
         RX_START: begin
            if (tick) begin
               st_nxt  = fsk_s ? RX_IDLE : RX_DATA;
               tmr_nxt = BIT_M1;
            end
         end
         RX_DATA: begin
            if (tick) begin
               st_nxt  = (cnt_r == 3'(DATA_BITS - 1)) ? RX_STOP : RX_DATA;
               tmr_nxt = BIT_M1;
            end
         end
         default: begin
            if (tick) begin
               st_nxt = RX_IDLE;
            end
         end
      endcase
      if (!cd_r) begin
         st_nxt = RX_IDLE;
      end
   end
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r   <= RX_IDLE;
         tmr_r  <= '0;
         cnt_r  <= '0;
         byte_r <= 8'h00;
      end else begin
         st_r  <= st_nxt;
         tmr_r <= tmr_nxt;
         cnt_r <= (st_r == RX_DATA) ? cnt_r + 3'(tick) : 3'h0;
         if (tick && st_r == RX_DATA) begin
            byte_r <= {fsk_s, byte_r[7:1]};
         end
      end
   end

   // nine-bit word buffer (byte plus stop bit), shift clock, data ready
   logic [8:0]    buf_r;
   logic          sdata_r;
   logic [TW-1:0] pls_r;
   logic [TW-1:0] dr_r;
   logic          last_stop_r;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         buf_r       <= 9'h1FF;
         sdata_r     <= 1'b1;
         pls_r       <= '0;
         dr_r        <= '0;
         last_stop_r <= 1'b1;
      end else begin
         pls_r <= tick ? HALF : ((pls_r == '0) ? '0 : pls_r - TW'(1));
         if (word_done) begin
            dr_r        <= HALF;
            last_stop_r <= fsk_s;
         end else if (mode1_s && host_rise) begin
            dr_r <= '0;
         end else if (dr_r != '0) begin
            dr_r <= dr_r - TW'(1);
         end
         if (word_done && mode1_s) begin
            buf_r <= {fsk_s, byte_r};
         end else if (mode1_s && host_rise) begin
            buf_r <= {1'b1, buf_r[8:1]};
         end
         if (!mode1_s) begin
            sdata_r <= cd_r ? fsk_s : 1'b1;
         end else if (host_rise) begin
            sdata_r <= buf_r[0];
         end
      end
   end
   assign o_serial_data         = sdata_r;
   assign o_data_shift_clock    = (pls_r != '0);
   assign o_data_shift_clock_oe = ~mode1_s & fsk_en;
   assign o_data_ready_or_tone_steering_n = fsk_en ? (dr_r == '0) : ~(tone_en & tone_s);

   // registers and interrupt
   logic [EV_N-1:0] stat_r;
   logic [EV_N-1:0] mask_r;
   logic            cd_d_r;
   wire  [EV_N-1:0] ev;
   assign ev[EV_WORD]  = word_done;
   assign ev[EV_FRAME] = word_done & ~fsk_s;
   assign ev[EV_CARR]  = cd_r & ~cd_d_r;
   wire  wr_stat = i_wr & (i_addr == ADDR_STATUS);
   wire  wr_mask = i_wr & (i_addr == ADDR_MASK);
   wire  [DW-1:0] rd_val;
   assign rd_val = (i_addr == ADDR_STATUS) ? DW'(stat_r) :
                   (i_addr == ADDR_MASK)   ? DW'(mask_r) :
                   (i_addr == ADDR_STATE)  ? DW'({pd, fsk_en, mode1_s, cd_r}) :
                   (i_addr == ADDR_WORD)   ? DW'({last_stop_r, byte_r}) : '0;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         stat_r  <= '0;
         mask_r  <= MASK_RST;
         cd_d_r  <= 1'b0;
         o_rdata <= '0;
      end else begin
         cd_d_r  <= cd_r;
         stat_r  <= (stat_r & ~(wr_stat ? i_wdata[EV_N-1:0] : '0)) | ev;
         mask_r  <= wr_mask ? i_wdata[EV_N-1:0] : mask_r;
         o_rdata <= i_rd ? rd_val : '0;
      end
   end
   assign o_irq = |(stat_r & mask_r);

   // checks: data ready
   a_dr_low_after:
      assert property (@(posedge i_clk) disable iff (i_reset) word_done && fsk_en |=>
         !o_data_ready_or_tone_steering_n ##1
         (!o_data_ready_or_tone_steering_n || $past(mode1_s && host_rise)))
         else $error("data ready not low");
   a_dr_width_m0:
      assert property (@(posedge i_clk) disable iff (i_reset)
         word_done && fsk_en && !mode1_s |=> !o_data_ready_or_tone_steering_n [*8])
         else $error("data ready pulse too short");
   a_dr_host_clear:
      assert property (@(posedge i_clk) disable iff (i_reset)
         mode1_s && host_rise && !word_done |=> dr_r == '0) else $error("ready not cleared");

   // checks: function select and power
   a_pd_decode:
      assert property (@(posedge i_clk) disable iff (i_reset)
         mode1_s && fs_s == FS_OFF |-> o_full_power_down && !o_tone_enable && !o_fsk_enable)
         else $error("power down missing");
   a_fsk_no_tone:
      assert property (@(posedge i_clk) disable iff (i_reset)
         fsk_en |-> !o_tone_enable && !o_full_power_down) else $error("tone on with fsk");
   a_osc_pd:
      assert property (@(posedge i_clk) disable iff (i_reset)
         pd |-> !o_oscillator_output) else $error("oscillator runs in power down");

   // checks: carrier detect
   a_cd_needs_fsk:
      assert property (@(posedge i_clk) disable iff (i_reset)
         !fsk_en |=> !cd_r) else $error("carrier active while fsk off");
   a_cd_hold:
      assert property (@(posedge i_clk) disable iff (i_reset)
         cd_r && carr_s && fsk_en |=> cd_r) else $error("carrier dropped while present");
   a_cd_stay_off:
      assert property (@(posedge i_clk) disable iff (i_reset)
         !cd_r && !carr_s |=> !cd_r) else $error("carrier rose without energy");
   a_cd_rise_src:
      assert property (@(posedge i_clk) disable iff (i_reset)
         $rose(cd_r) |-> $past(carr_s)) else $error("carrier rose on no signal");

   // checks: receiver
   a_rx_needs_cd:
      assert property (@(posedge i_clk) disable iff (i_reset)
         st_r != RX_IDLE |-> $past(cd_r)) else $error("receiving without carrier");
   a_rx_abort:
      assert property (@(posedge i_clk) disable iff (i_reset)
         !cd_r |=> st_r == RX_IDLE) else $error("word not aborted on carrier loss");
   a_rx_false_start:
      assert property (@(posedge i_clk) disable iff (i_reset)
         st_r == RX_START && tick && fsk_s |=> st_r == RX_IDLE) else $error("false start taken");
   a_rx_last_data:
      assert property (@(posedge i_clk) disable iff (i_reset)
         st_r == RX_DATA && tick && cnt_r == 3'h7 && cd_r |=> st_r == RX_STOP)
         else $error("stop bit not reached");
   a_byte_shift:
      assert property (@(posedge i_clk) disable iff (i_reset)
         st_r == RX_DATA && tick |=> byte_r[7] == $past(fsk_s)) else $error("data bit lost");
   a_word_stop:
      assert property (@(posedge i_clk) disable iff (i_reset)
         word_done |=> last_stop_r == $past(fsk_s)) else $error("stop bit not kept");

   // checks: serial interface
   a_clk_dir:
      assert property (@(posedge i_clk) disable iff (i_reset)
         mode1_s |-> !o_data_shift_clock_oe) else $error("shift clock driven in mode 1");
   a_clk_drive_m0:
      assert property (@(posedge i_clk) disable iff (i_reset)
         !mode1_s && fsk_en |-> o_data_shift_clock_oe) else $error("shift clock not driven");
   a_buf_load:
      assert property (@(posedge i_clk) disable iff (i_reset) word_done && mode1_s |=>
         buf_r == {$past(fsk_s), $past(byte_r)}) else $error("buffer load wrong");
   a_buf_shift:
      assert property (@(posedge i_clk) disable iff (i_reset) mode1_s && host_rise && !word_done
         |=> buf_r == {1'b1, $past(buf_r[8:1])}) else $error("buffer shift wrong");
   a_shift_order:
      assert property (@(posedge i_clk) disable iff (i_reset) mode1_s && host_rise |=>
         o_serial_data == $past(buf_r[0])) else $error("shift order wrong");
   a_frame_flag:
      assert property (@(posedge i_clk) disable iff (i_reset) word_done && !fsk_s |=>
         stat_r[EV_FRAME]) else $error("framing flag lost");
   a_frame_sticky:
      assert property (@(posedge i_clk) disable iff (i_reset)
         stat_r[EV_FRAME] && !(wr_stat && i_wdata[EV_FRAME]) |=> stat_r[EV_FRAME])
         else $error("framing flag not sticky");
   a_stream_out:
      assert property (@(posedge i_clk) disable iff (i_reset) !mode1_s && cd_r |=>
         o_serial_data == $past(fsk_s)) else $error("stream not passed");
   a_stream_idle:
      assert property (@(posedge i_clk) disable iff (i_reset) !mode1_s && !cd_r |=>
         o_serial_data) else $error("stream not idle without carrier");
   a_mid_pulse:
      assert property (@(posedge i_clk) disable iff (i_reset) tick |=>
         o_data_shift_clock [*2]) else $error("mid-bit pulse missing");
   a_pulse_src:
      assert property (@(posedge i_clk) disable iff (i_reset)
         $rose(o_data_shift_clock) |-> $past(tick)) else $error("stray shift pulse");
endmodule : cidfsk_serial
`default_nettype wire

// [tb/cidfsk_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cidfsk_host_model (
   input  wire logic i_start,
   input  wire logic i_serial_data,
   output logic      o_shift_clock,
   output logic [8:0] o_word,
   output logic      o_done
);
   initial begin
      o_shift_clock = 1'b0;
      o_word = 9'h000;
      o_done = 1'b0;
   end
   // nine 200 ns pulses, 400 ns apart, clock idle low between reads
   always @(posedge i_start) begin
      o_done = 1'b0;
      #7;
      for (int i = 0; i < 9; i++) begin
         o_shift_clock = 1'b1;
         #200;
         o_shift_clock = 1'b0;
         #190;
         o_word[i] = i_serial_data;
         #10;
      end
      o_done = 1'b1;
   end
endmodule : cidfsk_host_model
`default_nettype wire

// [tb/cidfsk_serial_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module cidfsk_serial_tb;
   import cidfsk_pkg::*;
   localparam int BITC = 40;
   logic          i_clk = 1'b0;
   logic          i_reset = 1'b1;
   logic          osc = 1'b0, mode = 1'b1, fsa = 1'b0, fsb = 1'b0;
   logic          line = 1'b1, carr = 1'b0, steer = 1'b0, wr = 1'b0, rd = 1'b0, hs = 1'b0;
   logic [AW-1:0] addr = '0;
   logic [DW-1:0] wdata = '0, rdata;
   logic [8:0]    hword;
   logic          hdone, data_shift_clock_in, data_shift_clock, data_shift_clock_oe, sdata, rdy_n, cd_n, fen, ten, tline, pd, osco, irq;
   int            error_cnt = 0, tests_run = 0, rdy_low = 0, data_shift_clock_cnt = 0;

   always #25 i_clk = ~i_clk;
   always @(posedge i_clk) if (rdy_n === 1'b0) rdy_low++;
   always @(posedge data_shift_clock) data_shift_clock_cnt++;

   cidfsk_serial #(.BIT_CYCLES(BITC), .CD_ON_CYC(20), .CD_OFF_CYC(20)) dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_oscillator_input(osc), .o_oscillator_output(osco),
      .i_interface_mode_select(mode), .i_function_select_a(fsa), .i_function_select_b(fsb),
      .i_line_fsk_bit(line), .i_line_carrier_raw(carr), .i_tone_delayed_steer(steer),
      .i_data_shift_clock(data_shift_clock_in), .o_data_shift_clock(data_shift_clock), .o_data_shift_clock_oe(data_shift_clock_oe),
      .o_serial_data(sdata), .o_data_ready_or_tone_steering_n(rdy_n), .o_carrier_present_n(cd_n),
      .o_fsk_enable(fen), .o_tone_enable(ten), .o_tone_from_line(tline),
      .o_full_power_down(pd), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .o_irq(irq));

   cidfsk_host_model host (.i_start(hs), .i_serial_data(sdata), .o_shift_clock(data_shift_clock_in),
      .o_word(hword), .o_done(hdone));

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic creg(input string n, input logic [3:0] a, input logic [31:0] e);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 chk(n, e, rdata);
   endtask : creg

   // one character, lsb first; c compares the mode 0 stream at mid-bit
   task automatic send(input logic [7:0] b, input logic s, input logic c);
      logic [9:0] f;
      f = {s, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk);
         line <= f[i];
         cyc(BITC / 2);
         if (c) chk("stream bit", f[i], sdata);
         cyc(BITC / 2 - 1);
      end
      @(posedge i_clk);
      line <= 1'b1;
   endtask : send

   function automatic logic [5:0] exp_sel(input logic m, input logic [1:0] f, input logic o);
      logic p;
      p = m & (f == FS_OFF);
      return {p, f == FS_FSK, ~p & (f != FS_FSK), f == FS_TONE_LINE, ~m & (f == FS_FSK), ~o & ~p};
   endfunction : exp_sel

   initial begin
      #400000;
      error_cnt++;
      summarize();
   end

   initial begin
      logic [7:0] b;
      void'($urandom(62755));
      cyc(19);
      chk("reset ready", 1, rdy_n);
      chk("reset carrier", 1, cd_n);
      @(posedge i_clk);
      i_reset <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge i_clk);
         {mode, fsb, fsa} <= i[2:0];
         osc <= 1'($urandom);
         steer <= 1'($urandom);
         cyc(5);
         chk("select", exp_sel(mode, {fsb, fsa}, osc), {pd, fen, ten, tline, data_shift_clock_oe, osco});
         if (!fen && !pd) chk("steer", {~(ten & steer)}, rdy_n);
      end
      $display("test select done");
      @(posedge i_clk);
      {mode, fsb, fsa} <= 3'b011;
      carr <= 1'b1;
      cyc(30);
      chk("carrier", 0, cd_n);
      creg("mask", ADDR_MASK, 32'h0);
      creg("status", ADDR_STATUS, 32'h4);
      wreg(ADDR_MASK, 32'h4);
      cyc(2);
      chk("irq on", 1, irq);
      wreg(ADDR_STATUS, 32'h4);
      cyc(2);
      chk("irq off", 0, irq);
      creg("unmapped", 4'h2, 32'h0);
      $display("test registers done");
      b = 8'($urandom);
      rdy_low = 0;
      data_shift_clock_cnt = 0;
      send(b, 1'b1, 1'b1);
      cyc(BITC);
      chk("shift pulses", 10, data_shift_clock_cnt);
      chk("ready width", BITC / 2, rdy_low);
      creg("word", ADDR_WORD, {23'h0, 1'b1, b});
      creg("status", ADDR_STATUS, 32'h1);
      wreg(ADDR_STATUS, 32'h7);
      $display("test stream done");
      @(posedge i_clk);
      mode <= 1'b1;
      cyc(5);
      creg("state", ADDR_STATE, 32'h7);
      for (int k = 0; k < 4; k++) begin
         b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         fork
            send(b, k != 2, 1'b0);
            begin
               for (int t = 0; t < 600 && rdy_n !== 1'b0; t++) @(posedge i_clk);
               chk("ready fell", 0, rdy_n);
               hs <= 1'b1;
               cyc(6);
               chk("ready cleared", 1, rdy_n);
               cyc(70);
               hs <= 1'b0;
               chk("host done", 1, hdone);
               chk("host word", {k != 2, b}, hword);
            end
         join
      end
      creg("status", ADDR_STATUS, 32'h3);
      $display("test buffer done");
      @(posedge i_clk);
      carr <= 1'b0;
      cyc(30);
      chk("carrier lost", 1, cd_n);
      wreg(ADDR_STATUS, 32'h7);
      rdy_low = 0;
      send(8'h5A, 1'b1, 1'b0);
      cyc(BITC);
      chk("ignored word", 0, rdy_low);
      creg("status idle", ADDR_STATUS, 32'h0);
      $display("test carrier done");
      summarize();
   end
endmodule : cidfsk_serial_tb
`default_nettype wire
